// *** bench/core_model.sv ***
`timescale 1ns/1ps
module core_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       core_reset,
    input  wire logic       core_start,
    input  wire logic [3:0] slow,
    output logic            core_ch_done
);
    // ------------------------------------------------------------------
    // converter core behaviour
    // ------------------------------------------------------------------
    logic [3:0] cnt;
    logic       busy;

    // one channel takes slow+1 cycles; a core reset aborts it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy         <= 1'b0;
            cnt          <= 4'h0;
            core_ch_done <= 1'b0;
        end else begin
            core_ch_done <= 1'b0;
            if (core_reset) begin
                busy <= 1'b0;
            end else if (core_start) begin
                busy <= 1'b1;
                cnt  <= slow;
            end else if (busy && cnt == 4'h0) begin
                busy         <= 1'b0;
                core_ch_done <= 1'b1;
            end else if (busy) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule

// *** bench/tb_adc_conversion_sequencer.sv ***
`timescale 1ns/1ps
module tb_adc_conversion_sequencer
    import convseq_pkg::*;
;
    // ------------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------------
    localparam int TD = 4;
    logic        clk, rst, hwrite, hsel, done_in, hready, hresp;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic        c_en, c_pwr, c_rst, c_start;
    logic [3:0]  c_ch, slow;
    logic [15:0] m, mk;
    int unsigned failures, num_checks, cyc, starts, rst_hi, s0, tw;
    int unsigned stamp[$], chq[$];

    adc_conversion_sequencer #(.TICK_DIV(TD)) adc_conversion_sequencer_i (
        .SYS_CLK(clk), .RST(rst), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HSEL(hsel), .HREADY(hready),
        .HWDATA(hwdata), .HRDATA(hrdata), .HREADYOUT(hready),
        .HRESP(hresp), .CORE_CH_DONE(done_in), .CORE_ENABLE(c_en),
        .CORE_POWER_ON(c_pwr), .CORE_RESET(c_rst), .CORE_CHANNEL(c_ch),
        .CORE_START(c_start));

    core_model core_model_i (.clk(clk), .rst(rst), .core_reset(c_rst),
        .core_start(c_start), .slow(slow), .core_ch_done(done_in));

    // ------------------------------------------------------------------
    // clock, monitor, watchdog
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // stamps each channel start so gaps can be measured afterwards
    always @(posedge clk) begin
        cyc++;
        if (c_start === 1'b1) begin
            starts++;
            stamp.push_back(cyc);
            chq.push_back(c_ch);
        end
        if (c_rst === 1'b1) rst_hi++;
    end

    // the whole run needs about 1000 cycles
    initial begin
        repeat (30000) @(posedge clk);
        failures++;
        end_of_test();
    end

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one single word transfer; read data lands in d
    task automatic bus(logic wr, logic [7:0] a, logic [31:0] wd);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {24'h00_0000, a};
        do @(posedge clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        d = hrdata;
    endtask

    task automatic wait_starts(int unsigned n);
        for (int i = 0; i < 3000 && starts < n; i++) @(posedge clk);
    endtask

    // polling keeps the bus busy too, a fair load for the register side
    task automatic wait_flag(int b);
        for (int i = 0; i < 200; i++) begin
            bus(1'b0, CTRL_OFS, '0);
            if (d[b] === 1'b1) break;
        end
    endtask

    task automatic note(string s);
        $display("test %s done", s);
    endtask

    task automatic end_of_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        haddr = '0;
        hwdata = '0;
        slow = 4'h2;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        s0 = $urandom(32'h6fa3);
        bus(1'b0, CTRL_OFS, '0);
        check("ctrl reset", d, CTRL_RESET);
        bus(1'b0, DELAY_OFS, '0);
        check("delay reset", d, DELAY_RESET);
        bus(1'b1, 8'h20, 32'hFFFF_FFFF);
        bus(1'b0, 8'h20, '0);
        check("unmapped", d, '0);
        bus(1'b1, DELAY_OFS, 32'h0010_0003);
        bus(1'b0, DELAY_OFS, '0);
        check("delay rw", d, 32'h0010_0003);
        s0 = rst_hi;
        bus(1'b1, CTRL_OFS, 32'h0000_0001);
        repeat (8) @(posedge clk);
        check("core reset pulse", rst_hi - s0, CORE_RST_CYCLES);
        note("registers");
        // one-shot cycles with random masks and core speeds
        for (int k = 0; k < 3; k++) begin
            m = 16'(($urandom & 32'h0000_FFFF) | 32'h0000_0001);
            slow <= 4'($urandom_range(6, 1));
            bus(1'b1, SINGLE_OFS, {16'h0000, m});
            s0 = starts;
            bus(1'b1, CTRL_OFS, 32'h0000_0003);
            tw = cyc;
            wait_flag(SGL_DONE_BIT);
            check("single starts", starts - s0, $countones(m));
            mk = '0;
            for (int i = s0; i < starts; i++) mk[chq[i]] = 1'b1;
            check("single chans", {16'h0000, mk}, {16'h0000, m});
            check("single latency", 32'(stamp[s0] - tw < TD * 2), 1);
            check("single clear", 32'(d[SINGLE_BIT]), '0);
            bus(1'b1, CTRL_OFS, 32'h0000_0001);
            bus(1'b0, CTRL_OFS, '0);
            check("done kept", 32'(d[SGL_DONE_BIT]), 1);
            bus(1'b1, CTRL_OFS, 32'h0000_0081);
            bus(1'b0, CTRL_OFS, '0);
            check("done cleared", 32'(d[SGL_DONE_BIT]), '0);
        end
        note("single");
        bus(1'b1, CTRL_OFS, '0);
        s0 = starts;
        bus(1'b1, CTRL_OFS, 32'h0000_0002);
        repeat (20) @(posedge clk);
        check("start while off", starts - s0, '0);
        check("off power", 32'(c_pwr), '0);
        bus(1'b1, CTRL_OFS, 32'h0000_0009);
        bus(1'b1, CTRL_OFS, 32'h0000_000B);
        wait_flag(SGL_DONE_BIT);
        repeat (10) @(posedge clk);
        check("power kept", 32'(c_pwr), 1);
        bus(1'b1, CTRL_OFS, 32'h0000_0081);
        repeat (10) @(posedge clk);
        check("power saved", 32'(c_pwr), '0);
        note("enable and power");
        // repeat mode: start delay 3 ticks, interval 16 ticks
        bus(1'b1, REPEAT_OFS, 32'h0000_0001);
        slow <= 4'h3;
        s0 = starts;
        bus(1'b1, CTRL_OFS, 32'h0000_0005);
        tw = cyc;
        wait_starts(s0 + 1);
        check("power in cycle", 32'(c_pwr & c_en), 1);
        repeat (30) @(posedge clk);
        check("enable in wait", 32'(c_en), '0);
        check("power in wait", 32'(c_pwr), '0);
        wait_starts(s0 + 3);
        check("repeat chan", chq[s0], '0);
        check("delay min", 32'(stamp[s0] - tw >= TD * 2), 1);
        check("delay max", 32'(stamp[s0] - tw <= TD * 4 + 8), 1);
        for (int k = 1; k < 3; k++) begin
            tw = stamp[s0 + k] - stamp[s0 + k - 1];
            check("interval", 32'(tw >= TD * 15 && tw <= TD * 17 + 20), 1);
        end
        bus(1'b0, CTRL_OFS, '0);
        check("repeat done", 32'(d[RPT_DONE_BIT]), 1);
        bus(1'b1, CTRL_OFS, 32'h0000_0041);
        repeat (10) @(posedge clk);
        s0 = starts;
        repeat (200) @(posedge clk);
        check("repeat stopped", starts - s0, '0);
        note("repeat");
        // disable in mid-cycle with a slow core
        bus(1'b1, SINGLE_OFS, 32'h0000_000F);
        slow <= 4'hC;
        s0 = starts;
        bus(1'b1, CTRL_OFS, 32'h0000_0003);
        wait_starts(s0 + 1);
        bus(1'b1, CTRL_OFS, '0);
        wait_starts(s0 + 4);
        repeat (30) @(posedge clk);
        check("cycle finished", starts - s0, 4);
        check("low power", 32'(c_pwr | c_en), '0);
        bus(1'b1, CTRL_OFS, 32'h0000_0011);
        repeat (4) @(posedge clk);
        check("soft reset held", 32'(c_rst), 1);
        bus(1'b0, SINGLE_OFS, '0);
        check("regs kept", d, 32'h0000_000F);
        bus(1'b1, CTRL_OFS, 32'h0000_0001);
        repeat (4) @(posedge clk);
        check("soft reset off", 32'(c_rst), '0);
        note("disable and soft reset");
        end_of_test();
    end
endmodule

// *** src/adc_conversion_sequencer.sv ***
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - soft reset holds core, keeps registers
// - power core down between sequences unless disabled
// - repeat start launches masked repeat cycles
// - repeat clear: finish cycle, stop timer
// - single start runs one masked cycle
// - single start bit clears itself
// - cycles only start while block enabled
// - enable rising edge pulses core reset
// - disable finishes cycle then low power
// - interval field spaces repeat cycles, 40us
// - interval only before second and later cycles
// - core enable only after wait expires
// - start delay before first repeat cycle
// - delays never apply to single start
// - single mask selects one-shot channels
// - repeat mask selects periodic channels
// - single done flag, write one clears
// - repeat done flag, sticky until cleared
module adc_conversion_sequencer
    import convseq_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic        HSEL,
    input  wire logic        HREADY,
    input  wire logic [31:0] HWDATA,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic        CORE_CH_DONE,
    output logic             CORE_ENABLE,
    output logic             CORE_POWER_ON,
    output logic             CORE_RESET,
    output logic      [3:0]  CORE_CHANNEL,
    output logic             CORE_START
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] rdata;
        logic        wr_pend;
        logic [7:0]  wr_addr;
        logic        block_enable;
        logic        single_go;
        logic        repeat_on;
        logic        idle_powerdown_disable;
        logic        soft_reset;
        logic        sgl_done;
        logic        rpt_done;
        logic [31:0] delay;
        logic [15:0] single_channel_mask;
        logic [15:0] periodic_channel_mask;
        logic [15:0] ch_status;
        logic [15:0] tick_cnt;
        logic [15:0] wait_cnt;
        logic        first_pass;
        logic        single_pend;
        logic        repeat_due;
        logic        cur_single;
        logic [15:0] cur_mask;
        logic [3:0]  chan;
        logic        start;
        logic        core_en;
        logic        power_on;
        logic [1:0]  rst_cnt;
        logic        core_rst;
        seq_state_t  st;
    } state_t;

    state_t cur_ff;
    state_t nxt_ff;

    logic [31:0] wdata;
    logic        tick;

    always_comb begin
        wdata = HWDATA;
        tick  = (cur_ff.tick_cnt == 16'(TICK_DIV - 1));
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_ff       = cur_ff;
        nxt_ff.start = 1'b0;
        // bus: latch address phase, commit write in data phase
        nxt_ff.wr_pend = 1'b0;
        if (cur_ff.wr_pend) begin
            unique case (cur_ff.wr_addr)
                CTRL_OFS: begin
                    if (!cur_ff.block_enable && wdata[ENABLE_BIT])
                        nxt_ff.rst_cnt = 2'(CORE_RST_CYCLES);
                    nxt_ff.block_enable = wdata[ENABLE_BIT];
                    nxt_ff.single_go = wdata[SINGLE_BIT];
                    if (wdata[REPEAT_BIT] && !cur_ff.repeat_on) begin
                        nxt_ff.first_pass = 1'b1;
                        nxt_ff.wait_cnt   = wdata[REPEAT_BIT] ?
                            cur_ff.delay[DELAY_FIELD_W-1:0] : 16'h0000;
                        nxt_ff.repeat_due = 1'b0;
                    end
                    if (!wdata[REPEAT_BIT]) begin
                        nxt_ff.wait_cnt   = 16'h0000;
                        nxt_ff.repeat_due = 1'b0;
                    end
                    nxt_ff.repeat_on = wdata[REPEAT_BIT];
                    nxt_ff.idle_powerdown_disable = wdata[PWRSAVE_DIS_BIT];
                    nxt_ff.soft_reset = wdata[SOFT_RST_BIT];
                    if (wdata[SGL_DONE_BIT]) nxt_ff.sgl_done = 1'b0;
                    if (wdata[RPT_DONE_BIT]) nxt_ff.rpt_done = 1'b0;
                end
                DELAY_OFS:  nxt_ff.delay = wdata;
                STATUS_OFS: nxt_ff.ch_status = cur_ff.ch_status &
                                               ~wdata[15:0];
                SINGLE_OFS: nxt_ff.single_channel_mask = wdata[15:0];
                REPEAT_OFS: nxt_ff.periodic_channel_mask = wdata[15:0];
                default: ;
            endcase
        end
        if (HSEL && HREADY && HTRANS[1]) begin
            nxt_ff.wr_pend = HWRITE;
            nxt_ff.wr_addr = HADDR[7:0];
            unique case (HADDR[7:0])
                CTRL_OFS: nxt_ff.rdata = {24'h00_0000,
                    cur_ff.sgl_done, cur_ff.rpt_done, 1'b0,
                    cur_ff.soft_reset, cur_ff.idle_powerdown_disable,
                    cur_ff.repeat_on, cur_ff.single_go,
                    cur_ff.block_enable};
                DELAY_OFS:  nxt_ff.rdata = cur_ff.delay;
                STATUS_OFS: nxt_ff.rdata = {16'h0000, cur_ff.ch_status};
                SINGLE_OFS: nxt_ff.rdata = {16'h0000,
                                            cur_ff.single_channel_mask};
                REPEAT_OFS: nxt_ff.rdata = {16'h0000,
                                            cur_ff.periodic_channel_mask};
                default:    nxt_ff.rdata = 32'h0000_0000;
            endcase
        end

        // core reset pulse after enable edge
        nxt_ff.core_rst = (cur_ff.rst_cnt != 2'd0) || cur_ff.soft_reset;
        if (cur_ff.rst_cnt != 2'd0)
            nxt_ff.rst_cnt = cur_ff.rst_cnt - 2'd1;

        // 40us prescaler feeding the delay timers
        nxt_ff.tick_cnt = tick ? 16'h0000 : cur_ff.tick_cnt + 16'd1;
        // count only while idle: a cycle in flight must not queue the next
        if (cur_ff.repeat_on && !cur_ff.repeat_due &&
            cur_ff.st == ST_IDLE) begin
            if (cur_ff.wait_cnt == 16'h0000)
                nxt_ff.repeat_due = 1'b1;
            else if (tick)
                nxt_ff.wait_cnt = cur_ff.wait_cnt - 16'd1;
        end
        if (cur_ff.single_go && cur_ff.block_enable) begin
            nxt_ff.single_pend = 1'b1;
        end
        if (cur_ff.single_go)
            nxt_ff.single_go = 1'b0;

        // sequencer; soft reset holds it idle, registers untouched
        if (cur_ff.soft_reset) begin
            nxt_ff.st      = ST_IDLE;
            nxt_ff.core_en = 1'b0;
        end else begin
            case (cur_ff.st)
                ST_IDLE: begin
                    // single first; a due repeat waits its turn
                    if (cur_ff.block_enable &&
                        (cur_ff.single_pend || cur_ff.repeat_due)) begin
                        nxt_ff.cur_single = cur_ff.single_pend;
                        nxt_ff.cur_mask   = cur_ff.single_pend ?
                            cur_ff.single_channel_mask :
                            cur_ff.periodic_channel_mask;
                        if (cur_ff.single_pend)
                            nxt_ff.single_pend = 1'b0;
                        else
                            nxt_ff.repeat_due = 1'b0;
                        nxt_ff.chan  = 4'h0;
                        nxt_ff.st    = ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // skip masked-off channels
                    if (cur_ff.cur_mask[cur_ff.chan]) begin
                        nxt_ff.core_en = 1'b1;
                        nxt_ff.start   = 1'b1;
                        nxt_ff.st      = ST_RUN;
                    end else if (cur_ff.chan == 4'hF) begin
                        nxt_ff.st = ST_DONE;
                    end else begin
                        nxt_ff.chan = cur_ff.chan + 4'h1;
                    end
                end
                ST_RUN: begin
                    // a running cycle completes even if disabled; only soft reset aborts it
                    if (CORE_CH_DONE) begin
                        nxt_ff.ch_status[cur_ff.chan] = 1'b1;
                        if (cur_ff.chan == 4'hF) begin
                            nxt_ff.st = ST_DONE;
                        end else begin
                            nxt_ff.chan = cur_ff.chan + 4'h1;
                            nxt_ff.st   = ST_WAIT;
                        end
                    end
                end
                ST_DONE: begin
                    nxt_ff.core_en = 1'b0;
                    if (cur_ff.cur_single) begin
                        nxt_ff.sgl_done = 1'b1;
                    end else begin
                        nxt_ff.rpt_done   = 1'b1;
                        nxt_ff.first_pass = 1'b0;
                        nxt_ff.wait_cnt   =
                            cur_ff.delay[31:INTERVAL_LSB];
                    end
                    nxt_ff.st = ST_IDLE;
                end
                default: nxt_ff.st = ST_IDLE;
            endcase
        end
        // powered through a cycle; between sequences only if saving is off
        nxt_ff.power_on = (cur_ff.st == ST_RUN || cur_ff.st == ST_WAIT) ||
                          (cur_ff.idle_powerdown_disable &&
                           cur_ff.block_enable);
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            cur_ff       <= '0;
            cur_ff.delay <= DELAY_RESET;
            cur_ff.st    <= ST_IDLE;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // outputs straight from flops; zero-wait bus, always OKAY
    always_comb begin
        HRDATA        = cur_ff.rdata;
        HREADYOUT     = 1'b1;
        HRESP         = 1'b0;
        CORE_ENABLE   = cur_ff.core_en;
        CORE_POWER_ON = cur_ff.power_on;
        CORE_RESET    = cur_ff.core_rst;
        CORE_CHANNEL  = cur_ff.chan;
        CORE_START    = cur_ff.start;
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_start_needs_enable: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        cur_ff.st == ST_WAIT && $past(cur_ff.st) == ST_IDLE |->
        $past(cur_ff.block_enable))
        else $error("cycle started while disabled");

    a_single_self_clear: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        cur_ff.single_go |=> !cur_ff.single_go)
        else $error("single start did not clear");

    a_enable_core_reset: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        $rose(cur_ff.block_enable) |=> CORE_RESET [*2])
        else $error("no core reset after enable");

    a_soft_reset_idle: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        cur_ff.soft_reset |=> cur_ff.st == ST_IDLE && !CORE_ENABLE)
        else $error("soft reset did not hold core");

    a_enable_after_wait: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        $rose(CORE_ENABLE) |-> $past(cur_ff.st) == ST_WAIT)
        else $error("core enabled outside a cycle");

    a_repeat_stop: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        !cur_ff.repeat_on && cur_ff.st == ST_IDLE |=>
        !cur_ff.repeat_due)
        else $error("repeat due after stop");

    a_single_done: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        cur_ff.st == ST_DONE && cur_ff.cur_single |=> cur_ff.sgl_done)
        else $error("single done not set");

    a_repeat_done: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        cur_ff.st == ST_DONE && !cur_ff.cur_single |=> cur_ff.rpt_done)
        else $error("repeat done not set");

    a_powerdown_idle: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        cur_ff.st == ST_IDLE && !cur_ff.idle_powerdown_disable
        ##1 cur_ff.st == ST_IDLE |-> !CORE_POWER_ON)
        else $error("core powered while idle");

    a_power_in_cycle: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        CORE_ENABLE |-> CORE_POWER_ON)
        else $error("core enabled without power");

endmodule

// *** src/convseq_pkg.sv ***
package convseq_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0]  CTRL_OFS    = 8'h00;
    localparam logic [7:0]  DELAY_OFS   = 8'h04;
    localparam logic [7:0]  STATUS_OFS  = 8'h08;
    localparam logic [7:0]  SINGLE_OFS  = 8'h0C;
    localparam logic [7:0]  REPEAT_OFS  = 8'h10;

    // ------------------------------------------------------------------
    // control and delay register fields
    // ------------------------------------------------------------------
    localparam int ENABLE_BIT      = 0;
    localparam int SINGLE_BIT      = 1;
    localparam int REPEAT_BIT      = 2;
    localparam int PWRSAVE_DIS_BIT = 3;
    localparam int SOFT_RST_BIT    = 4;
    localparam int RPT_DONE_BIT    = 6;
    localparam int SGL_DONE_BIT    = 7;
    localparam int DELAY_FIELD_W   = 16;
    localparam int INTERVAL_LSB    = 16;
    localparam int CHANNELS        = 16;

    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
    localparam logic [31:0] DELAY_RESET = 32'h0000_0000;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ        = 50;
    localparam int TICK_US        = 40;
    localparam int TICK_CYCLES    = TICK_US * CLK_MHZ;
    localparam int CORE_RST_CYCLES = 2;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_WAIT  = 3'b001,
        ST_RUN   = 3'b011,
        ST_DONE  = 3'b010
    } seq_state_t;

endpackage
